// file: rtl/arwc_consts.svh
`ifndef ARWC_CONSTS_SVH
`define ARWC_CONSTS_SVH
// register indices; byte address is four times the index
`define ARWC_IDX_ACCUM 6'h02
`define ARWC_IDX_MODE 6'h07
`define ARWC_IDX_MASK 6'h0a
`define ARWC_IDX_FLAGS 6'h0b
`define ARWC_IDX_RESULT 6'h10
`define ARWC_IDX_RESULT_HI 6'h11
`define ARWC_IDX_WINLO 6'h12
`define ARWC_IDX_WINLO_HI 6'h13
`define ARWC_IDX_WINHI 6'h14
`define ARWC_IDX_WINHI_HI 6'h15
`define ARWC_IDX_TUNE 6'h16
// field positions
`define ARWC_FLAG_DONE 0
`define ARWC_FLAG_MATCH 1
`define ARWC_DUTY_BIT 0
// reset values
`define ARWC_RST_THRESH 16'h0000
`define ARWC_RST_TUNE 8'h01
`define ARWC_RST_MODE 3'h0
`define ARWC_RST_ACCUM 3'h0
// sample limits and accumulation
`define ARWC_SAMPLE_MAX 10'h3ff
`define ARWC_SAMPLE_MIN 10'h000
`define ARWC_ACC_MAX_LOG2 3'h6
`define ARWC_ACC_CEIL 16'hffc0
// bus answers
`define ARWC_RESP_OKAY 2'b00
`define ARWC_RESP_SLVERR 2'b10
`endif

// file: rtl/arwc_pkg.sv
package arwc_pkg;
	// one sample from the conversion core
	typedef struct packed {
		logic valid;
		logic over;
		logic under;
		logic [9:0] data;
	} arwc_sample_type;
	// window comparison modes
	typedef enum logic [2:0] {
		ARWC_WIN_NONE = 3'b000,
		ARWC_WIN_BELOW = 3'b001,
		ARWC_WIN_ABOVE = 3'b010,
		ARWC_WIN_INSIDE = 3'b011,
		ARWC_WIN_OUTSIDE = 3'b100
	} arwc_mode_type;
	// sticky event flags
	typedef struct packed {
		logic match;
		logic done;
	} arwc_flags_type;
endpackage : arwc_pkg

// file: rtl/arwc_top.sv
// Overview of operation
// - the result reads as 16 bits with bits 15:8 as the upper byte and bit 15 the msb.
// - 10-bit samples, bit 9 msb, land in the low bits of the result.
// - result and sums are plain unsigned, 0x0000 zero and 0xffc0 the largest sum.
// - low threshold at 0x12, read/write, reset zero, feeds the window comparator.
// - high threshold at 0x14, read/write, reset zero, feeds the same comparator.
// - each threshold has its low byte at its base and its high byte at base plus one.
// - when accumulating only the final sum is compared, not each sample.
// - tuning register at 0x16 resets to 0x01; bit 0 picks 50 or 25 percent clock duty.
// - at the end of each measurement the match flag sets if the window mode holds.
// - match and done flags clear on a written one or on a result read; zero does nothing.
// - an input over the reference gives 0x3ff, one below zero gives 0x000.
// - the accumulated result never passes 0xffc0, even with 64 samples.
`timescale 1ns/100ps
`include "arwc_consts.svh"
`default_nettype none
module arwc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire arwc_pkg::arwc_sample_type sample_in,
	output logic clock_duty_select,
	output logic irq
);
	import arwc_pkg::*;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q && !awready_q;
	wire wr_fire = awready_q;
	wire rd_go = s_axi_arvalid && !rvalid_q && !arready_q;
	wire rd_fire = arready_q;
	wire [5:0] wr_idx = s_axi_awaddr[7:2];
	wire [5:0] rd_idx = s_axi_araddr[7:2];
	wire [7:0] wb0 = s_axi_wdata[7:0];
	wire [7:0] wb1 = s_axi_wdata[15:8];

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [15:0] result_q, winlo_q, winhi_q, acc_q;
	logic [7:0] tune_q;
	logic [2:0] accum_q;
	arwc_mode_type mode_q;
	arwc_flags_type flags_q, mask_q, flags_d;
	logic [6:0] cnt_q;
	logic irq_q;

	// write decode
	wire w_winlo = wr_fire && wr_idx == `ARWC_IDX_WINLO;
	wire w_winlo_hi = wr_fire && wr_idx == `ARWC_IDX_WINLO_HI;
	wire w_winhi = wr_fire && wr_idx == `ARWC_IDX_WINHI;
	wire w_winhi_hi = wr_fire && wr_idx == `ARWC_IDX_WINHI_HI;
	wire w_tune = wr_fire && wr_idx == `ARWC_IDX_TUNE && s_axi_wstrb[0];
	wire w_mode = wr_fire && wr_idx == `ARWC_IDX_MODE && s_axi_wstrb[0];
	wire w_accum = wr_fire && wr_idx == `ARWC_IDX_ACCUM && s_axi_wstrb[0];
	wire w_mask = wr_fire && wr_idx == `ARWC_IDX_MASK && s_axi_wstrb[0];
	wire w_flags = wr_fire && wr_idx == `ARWC_IDX_FLAGS && s_axi_wstrb[0];
	wire wr_hit = w_winlo | w_winlo_hi | w_winhi | w_winhi_hi
		| (wr_fire && (wr_idx == `ARWC_IDX_TUNE || wr_idx == `ARWC_IDX_MODE
		|| wr_idx == `ARWC_IDX_ACCUM || wr_idx == `ARWC_IDX_MASK
		|| wr_idx == `ARWC_IDX_FLAGS));

	// threshold byte lanes: full word at base, upper byte alone at base plus one
	wire [15:0] winlo_d = {
		w_winlo_hi && s_axi_wstrb[0] ? wb0 : (w_winlo && s_axi_wstrb[1] ? wb1 : winlo_q[15:8]),
		w_winlo && s_axi_wstrb[0] ? wb0 : winlo_q[7:0]};
	wire [15:0] winhi_d = {
		w_winhi_hi && s_axi_wstrb[0] ? wb0 : (w_winhi && s_axi_wstrb[1] ? wb1 : winhi_q[15:8]),
		w_winhi && s_axi_wstrb[0] ? wb0 : winhi_q[7:0]};

	// clamp the accumulation depth so 64 samples of 0x3ff is the worst sum
	wire [2:0] accum_d = wb0[2:0] > `ARWC_ACC_MAX_LOG2 ? `ARWC_ACC_MAX_LOG2 : wb0[2:0];
	wire [2:0] mode_raw = wb0[2:0];
	wire mode_ok = mode_raw <= ARWC_WIN_OUTSIDE;

	// ----------------------------------------
	// sample path and accumulation
	// ----------------------------------------
	// out-of-range flags from the core override its code
	wire [9:0] sample_clamped = sample_in.over ? `ARWC_SAMPLE_MAX
		: (sample_in.under ? `ARWC_SAMPLE_MIN : sample_in.data);
	wire [15:0] sum = acc_q + {6'h00, sample_clamped};
	wire [6:0] cnt_next = cnt_q + 7'd1;
	wire [6:0] cnt_goal = 7'd1 << accum_q;
	wire meas_end = sample_in.valid && cnt_next == cnt_goal;

	// comparison runs only on the finished sum, unsigned over all 16 bits
	wire below = sum < winlo_q;
	wire above = sum > winhi_q;
	logic hit;
	always_comb begin
		case (mode_q)
			ARWC_WIN_NONE: hit = 1'b0;
			ARWC_WIN_BELOW: hit = below;
			ARWC_WIN_ABOVE: hit = above;
			ARWC_WIN_INSIDE: hit = !below && !above;
			ARWC_WIN_OUTSIDE: hit = below || above;
			default: hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// sticky flags and interrupt
	// ----------------------------------------
	// a result read clears both flags; a new event in the same cycle wins
	wire res_read = rd_fire && (rd_idx == `ARWC_IDX_RESULT || rd_idx == `ARWC_IDX_RESULT_HI);
	wire [1:0] clr = (w_flags ? wb0[1:0] : 2'b00) | {2{res_read}};
	wire [1:0] setv = {meas_end && hit, meas_end};
	assign flags_d = (flags_q & ~clr) | setv;

	// register read mux
	logic [31:0] rd_val;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (rd_idx)
			`ARWC_IDX_RESULT: rd_val = {16'h0000, result_q};
			`ARWC_IDX_RESULT_HI: rd_val = {24'h000000, result_q[15:8]};
			`ARWC_IDX_WINLO: rd_val = {16'h0000, winlo_q};
			`ARWC_IDX_WINLO_HI: rd_val = {24'h000000, winlo_q[15:8]};
			`ARWC_IDX_WINHI: rd_val = {16'h0000, winhi_q};
			`ARWC_IDX_WINHI_HI: rd_val = {24'h000000, winhi_q[15:8]};
			`ARWC_IDX_TUNE: rd_val = {24'h000000, tune_q};
			`ARWC_IDX_MODE: rd_val = {29'h0, mode_q};
			`ARWC_IDX_ACCUM: rd_val = {29'h0, accum_q};
			`ARWC_IDX_MASK: rd_val = {30'h0, mask_q};
			`ARWC_IDX_FLAGS: rd_val = {30'h0, flags_q};
			default: begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// bus channel flops; each ready is a one-cycle pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `ARWC_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `ARWC_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else begin
			awready_q <= wr_go;
			wready_q <= wr_go;
			arready_q <= rd_go;
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `ARWC_RESP_OKAY : `ARWC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_val;
				rresp_q <= rd_ok ? `ARWC_RESP_OKAY : `ARWC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// software-written configuration
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			winlo_q <= `ARWC_RST_THRESH;
			winhi_q <= `ARWC_RST_THRESH;
			tune_q <= `ARWC_RST_TUNE;
			mode_q <= ARWC_WIN_NONE;
			accum_q <= `ARWC_RST_ACCUM;
			mask_q <= 2'b00;
		end else begin
			winlo_q <= winlo_d;
			winhi_q <= winhi_d;
			if (w_tune)
				tune_q <= {7'h00, wb0[`ARWC_DUTY_BIT]};
			if (w_mode && mode_ok)
				mode_q <= arwc_mode_type'(mode_raw);
			if (w_accum)
				accum_q <= accum_d;
			if (w_mask)
				mask_q <= wb0[1:0];
		end
	end

	// measurement state, flags and outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_q <= 16'h0000;
			cnt_q <= 7'h00;
			result_q <= 16'h0000;
			flags_q <= 2'b00;
			irq_q <= 1'b0;
			clock_duty_select <= 1'b1;
		end else begin
			if (meas_end) begin
				result_q <= sum;
				acc_q <= 16'h0000;
				cnt_q <= 7'h00;
			end else if (sample_in.valid) begin
				acc_q <= sum;
				cnt_q <= cnt_next;
			end
			flags_q <= flags_d;
			irq_q <= |(flags_d & mask_q);
			clock_duty_select <= tune_q[`ARWC_DUTY_BIT];
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign irq = irq_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_result_hi;
		rd_fire && rd_idx == `ARWC_IDX_RESULT_HI |=> rdata_q == {24'h0, result_q[15:8]};
	endproperty
	a_result_hi: assert property (p_result_hi) else $error("result high byte wrong");

	property p_sample_low;
		meas_end && accum_q == 3'h0 && acc_q == 16'h0
			|=> result_q == {6'h00, $past(sample_clamped)};
	endproperty
	a_sample_low: assert property (p_sample_low) else $error("sample not in low bits");

	property p_lo_write;
		w_winlo && s_axi_wstrb[1:0] == 2'b11 |=> winlo_q == $past(s_axi_wdata[15:0]);
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("low threshold write lost");

	property p_hi_byte;
		w_winhi_hi && s_axi_wstrb[0] |=> winhi_q[15:8] == $past(wb0) && $stable(winhi_q[7:0]);
	endproperty
	a_hi_byte: assert property (p_hi_byte) else $error("high threshold byte wrong");

	property p_no_sample_cmp;
		sample_in.valid && !meas_end |=> flags_q.match == $past(flags_q.match) || $past(clr[1]);
	endproperty
	a_no_sample_cmp: assert property (p_no_sample_cmp) else $error("match set mid-sum");

	property p_duty;
		w_tune |-> ##2 clock_duty_select == $past(wb0[0], 2);
	endproperty
	a_duty: assert property (p_duty) else $error("duty select not following");

	property p_match_set;
		meas_end && hit |=> flags_q.match && flags_q.done;
	endproperty
	a_match_set: assert property (p_match_set) else $error("match flag not set");

	property p_read_clear;
		res_read && !meas_end |=> flags_q == 2'b00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("result read kept flags");

	property p_zero_write;
		w_flags && wb0[1:0] == 2'b00 && !res_read |=> flags_q == ($past(flags_q) | $past(setv));
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag");

	property p_ceiling;
		result_q <= `ARWC_ACC_CEIL && accum_q <= `ARWC_ACC_MAX_LOG2;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("result above ceiling");

	// irq is registered from the next flags but the mask of the cycle before
	property p_irq;
		irq == |(flags_q & $past(mask_q));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	c_match: cover property (meas_end && hit);
	c_accum64: cover property (meas_end && accum_q == 3'h6);
	c_read_clear: cover property (res_read && flags_q.done);
	c_set_wins: cover property (meas_end && res_read);
endmodule : arwc_top
`default_nettype wire

// file: verif/arwc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module arwc_core_model (
	input wire logic clk,
	output var arwc_pkg::arwc_sample_type sample_in
);
	import arwc_pkg::*;
	// ------------------------------
	// conversion core stand-in
	// ------------------------------
	// idle cycles carry the inverted last data so a stale sample never passes for a new one
	initial sample_in = '0;
	// n conversions, g idle cycles after each (0 gives back-to-back samples)
	task automatic send(input logic [9:0] d, input logic o, input logic u, input int n,
		input int g);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			sample_in <= '{valid: 1'b1, over: o, under: u, data: d};
			repeat (g) begin
				@(posedge clk);
				sample_in <= '{valid: 1'b0, over: 1'b0, under: 1'b0, data: ~d};
			end
		end
		@(posedge clk);
		sample_in <= '{valid: 1'b0, over: 1'b0, under: 1'b0, data: ~d};
	endtask : send
endmodule : arwc_core_model
`default_nettype wire

// file: verif/adc_result_window_compare_tb_top.sv
`timescale 1ns/100ps
`include "arwc_consts.svh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module adc_result_window_compare_tb_top;
	import arwc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr = '0;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = '0;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	arwc_sample_type sample_in;
	logic clock_duty_select;
	logic irq;
	int error_cnt = 0;
	int checked = 0;
	// per mode: which of none/below/above/inside/outside should match, for 0x155 and 0x050
	logic [4:0] hit [2] = '{5'b01000, 5'b10010};
	// ------------------------------
	// clock, core and device
	// ------------------------------
	always #20 clk = ~clk;
	arwc_core_model core (.clk(clk), .sample_in(sample_in));
	arwc_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sample_in(sample_in), .clock_duty_select(clock_duty_select), .irq(irq));
	// ------------------------------
	// bus master tasks
	// ------------------------------
	// address and data offered together, each dropped at its own ready
	task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r = `ARWC_RESP_OKAY);
		@(posedge clk);
		awaddr <= {i, 2'b00};
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end while ((awvalid & ~awready) | (wvalid & ~wready));
		while (!bvalid) @(posedge clk);
		`CHK(bresp, r)
		bready <= 1'b0;
	endtask : wr
	// response code and data are checked together at the rvalid edge
	task automatic rd(input logic [5:0] i, input logic [31:0] e,
		input logic [1:0] r = `ARWC_RESP_OKAY);
		@(posedge clk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk);
		`CHK({rresp, rdata}, {r, e})
		rready <= 1'b0;
	endtask : rd
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// ------------------------------
	// tests
	// ------------------------------
	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`ARWC_IDX_TUNE, 32'h01);
		`CHK(clock_duty_select, 1'b1)
		rd(`ARWC_IDX_WINLO, 32'h0);
		rd(`ARWC_IDX_WINHI, 32'h0);
		rd(`ARWC_IDX_RESULT, 32'h0);
		rd(6'h3f, 32'h0, `ARWC_RESP_SLVERR);
		wr(6'h3e, 32'h0, 4'h1, `ARWC_RESP_SLVERR);
		// byte lanes of the thresholds
		wr(`ARWC_IDX_WINLO, 32'h1234, 4'h3);
		rd(`ARWC_IDX_WINLO, 32'h1234);
		wr(`ARWC_IDX_WINLO_HI, 32'hab, 4'h1);
		rd(`ARWC_IDX_WINLO, 32'hab34);
		rd(`ARWC_IDX_WINLO_HI, 32'hab);
		wr(`ARWC_IDX_WINHI, 32'h5678, 4'h1);
		rd(`ARWC_IDX_WINHI, 32'h78);
		wr(`ARWC_IDX_WINHI_HI, 32'h02, 4'h1);
		rd(`ARWC_IDX_WINHI, 32'h0278);
		// duty select follows the tuning bit a couple of edges after the write
		wr(`ARWC_IDX_TUNE, 32'h0, 4'h1);
		repeat (3) @(posedge clk);
		`CHK(clock_duty_select, 1'b0)
		rd(`ARWC_IDX_TUNE, 32'h0);
		// slow converter clock here, so software goes back to the 25 percent duty
		wr(`ARWC_IDX_TUNE, 32'h1, 4'h1);
		@(posedge clk);
		`CHK(clock_duty_select, 1'b1)
		// every window mode, one value inside and one below the window
		wr(`ARWC_IDX_WINLO, 32'h0100, 4'h3);
		wr(`ARWC_IDX_WINHI, 32'h0200, 4'h3);
		wr(`ARWC_IDX_MASK, 32'h3, 4'h1);
		for (int v = 0; v < 2; v++) begin
			for (int m = 0; m < 5; m++) begin
				wr(`ARWC_IDX_MODE, m, 4'h1);
				core.send(v ? 10'h050 : 10'h155, 1'b0, 1'b0, 1, 0);
				repeat (2) @(posedge clk);
				`CHK(irq, 1'b1)
				rd(`ARWC_IDX_FLAGS, {30'h0, hit[v][m], 1'b1});
				wr(`ARWC_IDX_FLAGS, 32'h3, 4'h1);
			end
		end
		rd(`ARWC_IDX_FLAGS, 32'h0);
		`CHK(irq, 1'b0)
		// zero writes do nothing, a one clears only its bit, a result read clears the rest
		wr(`ARWC_IDX_MODE, 32'h3, 4'h1);
		// an undefined mode code is ignored and the old mode stays
		wr(`ARWC_IDX_MODE, 32'h5, 4'h1);
		rd(`ARWC_IDX_MODE, 32'h3);
		core.send(10'h155, 1'b0, 1'b0, 1, 0);
		wr(`ARWC_IDX_FLAGS, 32'h0, 4'h1);
		rd(`ARWC_IDX_FLAGS, 32'h3);
		wr(`ARWC_IDX_FLAGS, 32'h2, 4'h1);
		rd(`ARWC_IDX_FLAGS, 32'h1);
		rd(`ARWC_IDX_RESULT, 32'h155);
		rd(`ARWC_IDX_FLAGS, 32'h0);
		// clipping flags from the core; over wins when both are set
		core.send(10'h123, 1'b1, 1'b1, 1, 0);
		rd(`ARWC_IDX_RESULT, 32'h3ff);
		core.send(10'h123, 1'b0, 1'b1, 1, 0);
		rd(`ARWC_IDX_RESULT, 32'h0);
		// masked events leave the interrupt low
		wr(`ARWC_IDX_MASK, 32'h0, 4'h1);
		core.send(10'h155, 1'b0, 1'b0, 1, 0);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr(`ARWC_IDX_MASK, 32'h1, 4'h1);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		rd(`ARWC_IDX_RESULT, 32'h155);
		`CHK(irq, 1'b0)
		// four samples each below the low threshold, whose sum is not
		wr(`ARWC_IDX_ACCUM, 32'h2, 4'h1);
		wr(`ARWC_IDX_MODE, 32'h1, 4'h1);
		wr(`ARWC_IDX_WINLO, 32'h0400, 4'h3);
		core.send(10'h300, 1'b0, 1'b0, 3, 0);
		rd(`ARWC_IDX_FLAGS, 32'h0);
		core.send(10'h300, 1'b0, 1'b0, 1, 0);
		rd(`ARWC_IDX_FLAGS, 32'h1);
		rd(`ARWC_IDX_RESULT, 32'h0c00);
		// depth beyond 64 samples clamps to 64
		wr(`ARWC_IDX_ACCUM, 32'h7, 4'h1);
		rd(`ARWC_IDX_ACCUM, 32'h6);
		// 64 full-scale samples, slow core, compared above a high threshold using bit 15
		wr(`ARWC_IDX_ACCUM, 32'h6, 4'h1);
		wr(`ARWC_IDX_MODE, 32'h2, 4'h1);
		wr(`ARWC_IDX_WINHI, 32'h8000, 4'h3);
		core.send(10'h2aa, 1'b1, 1'b0, 64, 1);
		rd(`ARWC_IDX_FLAGS, 32'h3);
		rd(`ARWC_IDX_RESULT_HI, 32'hff);
		rd(`ARWC_IDX_RESULT, 32'hffc0);
		close_out();
	end
endmodule : adc_result_window_compare_tb_top
`default_nettype wire
